// ### lf_wakeup_cfg.svh
// timing constants, register addresses and status bit positions for the wake-up header filter
`ifndef LF_WAKEUP_CFG_SVH
`define LF_WAKEUP_CFG_SVH
// system clock rate, kHz
`define CLK_KHZ 20000
// internal rc oscillator rate, kHz (one tick per divider wrap)
`define RC_KHZ 32
// settling time in microseconds, and the matching number of rc ticks
`define AGC_SETTLE_US 3500
`define AGC_SETTLE_TICKS ((`AGC_SETTLE_US * `RC_KHZ) / 1000)
// gap after settling and the restart gap after an overlong high, in microseconds
`define SETTLE_GAP_US 500
`define SETTLE_GAP_TICKS ((`SETTLE_GAP_US * `RC_KHZ) / 1000)
`define RESTART_GAP_US 500
`define RESTART_GAP_TICKS ((`RESTART_GAP_US * `RC_KHZ) / 1000)
// longest tolerated carrier dropout during the high, in microseconds
`define DROPOUT_US 56
`define DROPOUT_TICKS ((`DROPOUT_US * `RC_KHZ + 999) / 1000)
// alarm time for a signal that never passes, in microseconds
`define ALARM_US 32000
`define ALARM_TICKS ((`ALARM_US * `RC_KHZ) / 1000)
// duration table in milliseconds; ticks are ms times rc kHz
`define MS_1 1
`define MS_2 2
`define MS_3 3
`define MS_4 4
`define MS_5 5
`define MS_6 6
`define MS_8 8
`define MS_10 10
// register addresses on the software port
`define ADDR_CFG0 3'h0
`define ADDR_CFG5 3'h5
`define ADDR_STAT 3'h7
// status bit positions
`define STAT_WAKE_LSB 2
`define STAT_AGC_BIT 5
// reset value of the status word
`define STAT_RESET 9'h000
`endif

// ### lf_wakeup_pkg.sv
// types shared by the wake-up header filter files
package lf_wakeup_pkg;
  // filter configuration as written by software
  typedef struct packed {
    logic [1:0] headerHighSel;
    logic [1:0] headerLowSel;
    logic agcGatedOutputEn;
  } filter_cfg_t;
  // settling phases
  typedef enum logic [2:0] {SET_IDLE, SET_SETTLE, SET_GAP, SET_RUN} settle_st_t;
  // filter phases
  typedef enum logic [2:0] {FLT_WAIT_RISE, FLT_HIGH, FLT_LOW, FLT_PASS, FLT_RESTART_GAP} filt_st_t;
endpackage : lf_wakeup_pkg

// ### rc_tick_gen.sv
// divides the system clock into ticks of the internal rc oscillator
`timescale 1ns/1ps
`include "lf_wakeup_cfg.svh"
module rc_tick_gen #(
  parameter int CLK_KHZ = `CLK_KHZ,
  parameter int RC_KHZ = `RC_KHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstSync_b,
  // restart the oscillator phase on soft reset
  input wire logic restart,
  // one cycle per rc period
  output logic tick
);
  localparam int DIV = CLK_KHZ / RC_KHZ;
  initial begin
    if (DIV < 2) $error("rc_tick_gen: divider too small");
  end
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } st_t;
  st_t st_r, st_nxt;
  // count down, wrap and pulse
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (restart) begin
      st_nxt.cnt = 16'(DIV - 1);
    end else if (st_r.cnt == 16'h0000) begin
      st_nxt.cnt = 16'(DIV - 1);
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt - 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) st_r <= '0;
    else st_r <= st_nxt;
  end
  assign tick = st_r.tick;
endmodule : rc_tick_gen

// ### filter_limits.sv
// looks up minimum high, minimum low and maximum period in rc ticks
`timescale 1ns/1ps
`include "lf_wakeup_cfg.svh"
module filter_limits #(
  parameter int W = 10
) (
  // selections
  input wire logic [1:0] headerHighSel,
  input wire logic [1:0] headerLowSel,
  // limits
  output logic [W-1:0] minHighTime,
  output logic [W-1:0] minLowTime,
  output logic [W-1:0] maxPeriodTime
);
  initial begin
    if (W < 9) $error("filter_limits: width too small for 10 ms");
  end
  // table lookup, constants in ms scaled to ticks
  always_comb begin
    int hi, lo, per;
    hi = `MS_1;
    lo = `MS_1;
    per = `MS_3;
    case (headerHighSel)
      2'h2: hi = `MS_2;
      2'h3: hi = `MS_4;
      default: hi = `MS_1;
    endcase
    case (headerLowSel)
      2'h2: lo = `MS_2;
      2'h3: lo = `MS_4;
      default: lo = `MS_1;
    endcase
    // period grows with both selections
    case ({hi[2:0], lo[2:0]})
      {3'h1, 3'h1}: per = `MS_3;
      {3'h1, 3'h2}: per = `MS_4;
      {3'h1, 3'h4}: per = `MS_6;
      {3'h2, 3'h1}: per = `MS_4;
      {3'h2, 3'h2}: per = `MS_5;
      {3'h2, 3'h4}: per = `MS_8;
      {3'h4, 3'h1}: per = `MS_6;
      {3'h4, 3'h2}: per = `MS_8;
      {3'h4, 3'h4}: per = `MS_10;
      default: per = `MS_10;
    endcase
    minHighTime = W'(hi * `RC_KHZ);
    minLowTime = W'(lo * `RC_KHZ);
    maxPeriodTime = W'(per * `RC_KHZ);
  end
endmodule : filter_limits

// ### lf_wakeup_header_filter.sv
// wake-up qualification: agc settling timer and configurable header filter
// Functional notes
// - hold filter reset for 3.5 ms settling
// - input low at settle end aborts, soft reset
// - per-channel wake bits in status 4:2
// - data output disabled until header matches
// - high select 1/2/4 ms, low 1/1/2/4
// - maximum period 3 to 10 ms
// - high rise-to-fall within min and max
// - low fall-to-rise within min and max
// - high plus low must not exceed max
// - high select 00 disables filter, passes all
// - violations reset filter, need new sequence
// - dropout over 56 us during high resets; code resets only before minimum high, later the dropout starts the low phase
// - serial soft reset command resets filter
// - after long high, gap then new rise
// - filter starts right after settle gap
// - agc active flag in status bit 5
// - gated option holds outputs until agc active
// - all timing counted on 32 kHz ticks
// - OR of three channels feeds filter
// - alarm after 32 ms failing signal
// - soft reset leaves configuration unchanged
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
`include "lf_wakeup_cfg.svh"
module lf_wakeup_header_filter #(
  parameter int CH = 3,
  parameter int CW = 11
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // sliced data per channel, carrier clock and agc regulating level
  input wire logic [CH-1:0] chanData,
  input wire logic carrierClk,
  input wire logic agcRegulating,
  // serial command decode strobes
  input wire logic softResetCmd,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [8:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [8:0] regRdata,
  // pins and flags to the microcontroller side
  output logic demodDataOut,
  output logic carrierOut,
  output logic dataEnabled,
  output logic alarm,
  output logic softResetPulse
);
  // register 0 holds header selections, register 5 the gated option, register 7 status
  localparam logic [2:0] ADDR_CFG0 = `ADDR_CFG0;
  localparam logic [2:0] ADDR_CFG5 = `ADDR_CFG5;
  localparam logic [2:0] ADDR_STAT = `ADDR_STAT;
  initial begin
    if (CH != 3) $error("lf_wakeup_header_filter: three channels only");
    if (CW < 11) $error("lf_wakeup_header_filter: counter too narrow");
  end

  // reset synchroniser, release through two flops
  logic rstMeta_r, rstSync_b;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_r <= 1'b0;
      rstSync_b <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_b <= rstMeta_r;
    end
  end

  // whole module state
  typedef struct packed {
    lf_wakeup_pkg::filter_cfg_t cfg;
    lf_wakeup_pkg::settle_st_t sst;
    lf_wakeup_pkg::filt_st_t fst;
    logic [CW-1:0] settleCnt;
    logic [CW-1:0] highCnt;
    logic [CW-1:0] lowCnt;
    logic [CW-1:0] gapCnt;
    logic [CW-1:0] alarmCnt;
    logic [2:0] wakeBits;
    logic dataPrev;
    logic agcFlag;
    logic enabled;
    logic alarm;
    logic softRst;
    logic dout;
    logic cout;
    logic [8:0] rdata;
  } st_t;
  st_t st_r, st_nxt;

  logic tick;
  logic [CW-1:0] minHighTime, minLowTime, maxPeriodTime;
  logic dataOr;

  // rc tick, restarted on soft reset
  rc_tick_gen u_tick (
    .clk(clk),
    .rstSync_b(rstSync_b),
    .restart(st_r.softRst),
    .tick(tick)
  );

  // duration limits from the selections
  filter_limits #(.W(CW)) u_lim (
    .headerHighSel(st_r.cfg.headerHighSel),
    .headerLowSel(st_r.cfg.headerLowSel),
    .minHighTime(minHighTime),
    .minLowTime(minLowTime),
    .maxPeriodTime(maxPeriodTime)
  );

  // combine channels before the filter
  assign dataOr = |chanData;

  // next-state logic
  always_comb begin
    logic filterOff, rise, fall, softEvt, fltReset;
    filterOff = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    softEvt = 1'b0;
    fltReset = 1'b0;
    st_nxt = st_r;
    st_nxt.softRst = 1'b0;
    st_nxt.rdata = 9'h000;
    filterOff = (st_r.cfg.headerHighSel == 2'h0);
    rise = dataOr && !st_r.dataPrev;
    fall = !dataOr && st_r.dataPrev;
    st_nxt.agcFlag = agcRegulating;

    // register writes steer the filter; configuration survives soft reset
    if (regWr && regAddr == ADDR_CFG0) begin
      st_nxt.cfg.headerHighSel = regWdata[8:7];
      st_nxt.cfg.headerLowSel = regWdata[6:5];
    end
    if (regWr && regAddr == ADDR_CFG5) begin
      st_nxt.cfg.agcGatedOutputEn = regWdata[7];
    end
    // reads answer next cycle; unmapped addresses read zero
    if (regRd) begin
      case (regAddr)
        ADDR_CFG0: st_nxt.rdata = {st_r.cfg.headerHighSel, st_r.cfg.headerLowSel, 5'h00};
        ADDR_CFG5: st_nxt.rdata = {1'b0, st_r.cfg.agcGatedOutputEn, 7'h00};
        ADDR_STAT: st_nxt.rdata = {3'h0, st_r.agcFlag, st_r.wakeBits, 2'h0};
        default: st_nxt.rdata = 9'h000;
      endcase
    end

    // settling timer, counted in rc ticks
    if (tick) st_nxt.dataPrev = dataOr;
    case (st_r.sst)
      lf_wakeup_pkg::SET_IDLE: begin
        if (dataOr) begin
          st_nxt.sst = lf_wakeup_pkg::SET_SETTLE;
          st_nxt.settleCnt = '0;
        end
      end
      lf_wakeup_pkg::SET_SETTLE: begin
        if (tick) begin
          st_nxt.settleCnt = st_r.settleCnt + 1'b1;
          if (st_r.settleCnt == CW'(`AGC_SETTLE_TICKS - 1)) begin
            if (!dataOr) begin
              softEvt = 1'b1;
            end else begin
              st_nxt.wakeBits = st_r.wakeBits | chanData;
              st_nxt.sst = lf_wakeup_pkg::SET_GAP;
              st_nxt.gapCnt = '0;
            end
          end
        end
      end
      lf_wakeup_pkg::SET_GAP: begin
        if (tick) begin
          st_nxt.gapCnt = st_r.gapCnt + 1'b1;
          if (st_r.gapCnt == CW'(`SETTLE_GAP_TICKS - 1)) begin
            st_nxt.sst = lf_wakeup_pkg::SET_RUN;
            st_nxt.fst = lf_wakeup_pkg::FLT_WAIT_RISE;
            st_nxt.dataPrev = 1'b0;
            st_nxt.alarmCnt = '0;
          end
        end
      end
      lf_wakeup_pkg::SET_RUN: begin
        // header evaluation on every rc tick
        if (tick) begin
          case (st_r.fst)
            lf_wakeup_pkg::FLT_WAIT_RISE: begin
              if (rise || (dataOr && st_r.highCnt == '0)) begin
                st_nxt.fst = lf_wakeup_pkg::FLT_HIGH;
                st_nxt.highCnt = CW'(1);
                st_nxt.lowCnt = '0;
              end
            end
            lf_wakeup_pkg::FLT_HIGH: begin
              if (dataOr) begin
                st_nxt.highCnt = st_r.highCnt + 1'b1;
                st_nxt.lowCnt = '0;
                if (st_r.highCnt >= maxPeriodTime) begin
                  fltReset = 1'b1;
                  st_nxt.fst = lf_wakeup_pkg::FLT_RESTART_GAP;
                  st_nxt.gapCnt = '0;
                end
              end else if (st_r.lowCnt < CW'(`DROPOUT_TICKS)) begin
                // short dropout: tolerated, still timing high
                st_nxt.lowCnt = st_r.lowCnt + 1'b1;
                st_nxt.highCnt = st_r.highCnt + 1'b1;
              end else if (st_r.highCnt < minHighTime) begin
                fltReset = 1'b1;
              end else begin
                st_nxt.fst = lf_wakeup_pkg::FLT_LOW;
              end
            end
            lf_wakeup_pkg::FLT_LOW: begin
              if (!dataOr) begin
                st_nxt.lowCnt = st_r.lowCnt + 1'b1;
                if (st_r.lowCnt >= maxPeriodTime ||
                    st_r.highCnt + st_r.lowCnt >= maxPeriodTime) begin
                  fltReset = 1'b1;
                end
              end else if (st_r.lowCnt < minLowTime) begin
                fltReset = 1'b1;
              end else begin
                st_nxt.fst = lf_wakeup_pkg::FLT_PASS;
              end
            end
            lf_wakeup_pkg::FLT_PASS: begin
              st_nxt.fst = lf_wakeup_pkg::FLT_PASS;
            end
            lf_wakeup_pkg::FLT_RESTART_GAP: begin
              if (st_r.gapCnt >= CW'(`RESTART_GAP_TICKS) && rise) begin
                st_nxt.fst = lf_wakeup_pkg::FLT_HIGH;
                st_nxt.highCnt = CW'(1);
                st_nxt.lowCnt = '0;
              end else if (st_r.gapCnt < CW'(`RESTART_GAP_TICKS)) begin
                st_nxt.gapCnt = st_r.gapCnt + 1'b1;
              end
            end
            default: st_nxt.fst = lf_wakeup_pkg::FLT_WAIT_RISE;
          endcase
          // alarm on a signal that keeps failing
          if (!filterOff && st_r.fst != lf_wakeup_pkg::FLT_PASS && dataOr) begin
            if (st_r.alarmCnt >= CW'(`ALARM_TICKS - 1)) st_nxt.alarm = 1'b1;
            else st_nxt.alarmCnt = st_r.alarmCnt + 1'b1;
          end
        end
        if (fltReset) begin
          st_nxt.highCnt = '0;
          st_nxt.lowCnt = '0;
          if (st_nxt.fst != lf_wakeup_pkg::FLT_RESTART_GAP) st_nxt.fst = lf_wakeup_pkg::FLT_WAIT_RISE;
        end
      end
      default: st_nxt.sst = lf_wakeup_pkg::SET_IDLE;
    endcase

    // alarm clears when filter is off or output enabled
    if (filterOff || st_r.enabled) begin
      st_nxt.alarm = 1'b0;
      st_nxt.alarmCnt = '0;
    end
    // enable when the header passed or the filter is off
    st_nxt.enabled = (st_r.sst == lf_wakeup_pkg::SET_RUN) &&
                     (filterOff || st_nxt.fst == lf_wakeup_pkg::FLT_PASS);

    // soft reset reinitialises settling and filter state; configuration, wake bits and alarm are kept
    if (softResetCmd || softEvt) begin
      st_nxt.softRst = 1'b1;
      st_nxt.sst = lf_wakeup_pkg::SET_IDLE;
      st_nxt.fst = lf_wakeup_pkg::FLT_WAIT_RISE;
      st_nxt.settleCnt = '0;
      st_nxt.highCnt = '0;
      st_nxt.lowCnt = '0;
      st_nxt.gapCnt = '0;
      st_nxt.alarmCnt = '0;
      st_nxt.enabled = 1'b0;
      st_nxt.dataPrev = 1'b0;
      st_nxt.cfg = st_r.cfg;
    end

    // data output gated by enable, both outputs optionally by agc activity
    st_nxt.dout = st_r.enabled && dataOr &&
                  (!st_r.cfg.agcGatedOutputEn || st_r.agcFlag);
    st_nxt.cout = carrierClk && (!st_r.cfg.agcGatedOutputEn || st_r.agcFlag);
  end

  // state register
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdata = st_r.rdata;
  assign demodDataOut = st_r.dout;
  assign carrierOut = st_r.cout;
  assign dataEnabled = st_r.enabled;
  assign alarm = st_r.alarm;
  assign softResetPulse = st_r.softRst;

  // data never appears before the enable
  chk_data_gated: assert property (@(posedge clk) disable iff (!rstSync_b)
    demodDataOut |-> $past(st_r.enabled))
    else $error("data output while filter not passed");
  // filter off means no enable without running state
  chk_enable_run: assert property (@(posedge clk) disable iff (!rstSync_b)
    dataEnabled |-> $past(st_r.sst) == lf_wakeup_pkg::SET_RUN)
    else $error("output enabled outside run phase");
  // command soft reset drops the enable next cycle
  chk_soft_reset: assert property (@(posedge clk) disable iff (!rstSync_b)
    softResetCmd |=> !dataEnabled && softResetPulse)
    else $error("soft reset did not clear enable");
  // gating by agc
  chk_agc_gate: assert property (@(posedge clk) disable iff (!rstSync_b)
    (st_r.cfg.agcGatedOutputEn && !st_r.agcFlag) |=> !demodDataOut && !carrierOut)
    else $error("output while agc inactive and gated");
  // agc flag follows its source one cycle later
  chk_agc_flag: assert property (@(posedge clk) disable iff (!rstSync_b)
    agcRegulating |=> st_r.agcFlag)
    else $error("agc flag not set");
  // configuration kept across soft reset
  chk_cfg_keep: assert property (@(posedge clk) disable iff (!rstSync_b)
    (softResetCmd && !regWr) |=> $stable(st_r.cfg))
    else $error("soft reset changed configuration");
  // pass holds until a reset event
  chk_pass_hold: assert property (@(posedge clk) disable iff (!rstSync_b)
    (dataEnabled && !softResetCmd && !st_nxt.softRst && st_r.cfg.headerHighSel != 2'h0
     && $stable(st_r.cfg)) |=> dataEnabled)
    else $error("enable dropped without reset");
  // alarm only with the filter on
  chk_alarm_off: assert property (@(posedge clk) disable iff (!rstSync_b)
    (st_r.cfg.headerHighSel == 2'h0) |=> ##1 !alarm)
    else $error("alarm with filter disabled");
endmodule : lf_wakeup_header_filter

// ### mcu_model.sv
// behavioural microcontroller woken by the demodulated data pin
`timescale 1ns/1ps
module mcu_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pins from the front end
  input wire logic demodDataOut,
  input wire logic dataEnabled,
  // wake state seen by the bench
  output logic woken
);
  // wakes only on data seen while the pin is enabled, so a stray level before
  // qualification never counts as a wake
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      woken <= 1'b0;
    end else if (dataEnabled && demodDataOut) begin
      woken <= 1'b1;
    end
  end
endmodule : mcu_model

// ### lf_wakeup_header_filter_bench.sv
// self-checking bench for the wake-up header filter
`timescale 1ns/1ps
module lf_wakeup_header_filter_bench;
  // clock and reset
  logic clk;
  logic rst_b;
  // front-end stimulus
  logic [2:0] chanData;
  logic carrierClk;
  logic agcRegulating;
  logic softResetCmd;
  // register port
  logic [2:0] regAddr;
  logic [8:0] regWdata;
  logic regWr;
  logic regRd;
  logic [8:0] regRdata;
  // outputs
  logic demodDataOut;
  logic carrierOut;
  logic dataEnabled;
  logic alarm;
  logic softResetPulse;
  logic woken;
  // bookkeeping
  int err_count;
  int check_count;
  int pulses;
  int waited;
  logic [8:0] rd;

  lf_wakeup_header_filter uut (
    .clk(clk),
    .rst_b(rst_b),
    .chanData(chanData),
    .carrierClk(carrierClk),
    .agcRegulating(agcRegulating),
    .softResetCmd(softResetCmd),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr),
    .regRd(regRd),
    .regRdata(regRdata),
    .demodDataOut(demodDataOut),
    .carrierOut(carrierOut),
    .dataEnabled(dataEnabled),
    .alarm(alarm),
    .softResetPulse(softResetPulse)
  );

  mcu_model partner (
    .clk(clk),
    .rst_b(rst_b),
    .demodDataOut(demodDataOut),
    .dataEnabled(dataEnabled),
    .woken(woken)
  );

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // compare and count; case inequality so an unknown never matches
  task check(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // single closing point of the run
  task print_verdict;
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // one-cycle write strobe
  task regWrite(input logic [2:0] a, input logic [8:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : regWrite

  // one-cycle read strobe; data stands only in the following cycle
  task regRead(input logic [2:0] a, output logic [8:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask : regRead

  // command pulse, then count reset pulses over a short window
  task softReset;
    @(posedge clk);
    softResetCmd <= 1'b1;
    @(posedge clk);
    softResetCmd <= 1'b0;
    pulses = 0;
    repeat (4) begin
      #1;
      if (softResetPulse === 1'b1) pulses++;
      @(posedge clk);
    end
  endtask : softReset

  initial begin
    rst_b = 1'b0;
    chanData = 3'h0;
    carrierClk = 1'b0;
    agcRegulating = 1'b0;
    softResetCmd = 1'b0;
    regAddr = 3'h0;
    regWdata = 9'h000;
    regWr = 1'b0;
    regRd = 1'b0;
    err_count = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    // internal reset copy needs two edges before the first request
    repeat (3) @(posedge clk);
    regRead(3'h7, rd);
    check(rd, 9'h000);
    regRead(3'h0, rd);
    check(rd & 9'h1E0, 9'h000);
    // gated option on; stray write to an unmapped place must be ignored
    regWrite(3'h5, 9'h080);
    regWrite(3'h3, 9'h1FF);
    regRead(3'h3, rd);
    check(rd, 9'h000);
    softReset;
    check(9'(pulses), 9'h001);
    regRead(3'h5, rd);
    check(rd & 9'h080, 9'h080);
    // channels 0 and 2 wake with an unbroken high
    @(posedge clk);
    chanData <= 3'h5;
    carrierClk <= 1'b1;
    waited = 0;
    while (dataEnabled !== 1'b1 && waited < 90000) begin
      @(posedge clk);
      #1;
      waited++;
    end
    if (waited >= 90000) begin
      err_count++;
      $display("mismatch at %0t: wake timeout", $time);
      print_verdict;
    end
    // settle 112 ticks plus gap 16 ticks at 625 clocks per tick
    check(9'(waited >= 79000 && waited <= 81500), 9'h001);
    check(9'(alarm), 9'h000);
    repeat (2) @(posedge clk);
    #1;
    check(9'(demodDataOut), 9'h000);
    check(9'(carrierOut), 9'h000);
    regRead(3'h7, rd);
    check(rd & 9'h03C, 9'h014);
    @(posedge clk);
    agcRegulating <= 1'b1;
    // flag registers in one cycle and the gated pins follow in the next
    repeat (4) @(posedge clk);
    #1;
    check(9'(demodDataOut), 9'h001);
    check(9'(carrierOut), 9'h001);
    regRead(3'h7, rd);
    check(rd & 9'h03C, 9'h034);
    @(posedge clk);
    chanData <= 3'h0;
    // four rc ticks with the data low; the filter is off, so the enable holds
    repeat (2500) @(posedge clk);
    #1;
    check(9'(demodDataOut), 9'h000);
    check(9'(dataEnabled), 9'h001);
    check(9'(woken), 9'h001);
    // filter on mid-run with 1 ms high and 1 ms low: no header seen yet
    regWrite(3'h0, 9'h080);
    repeat (3) @(posedge clk);
    #1;
    check(9'(dataEnabled), 9'h000);
    regRead(3'h0, rd);
    check(rd & 9'h1E0, 9'h080);
    // a high of about five ticks is far below the 32-tick minimum
    @(posedge clk);
    chanData <= 3'h1;
    repeat (3000) @(posedge clk);
    #1;
    check(9'(demodDataOut), 9'h000);
    @(posedge clk);
    chanData <= 3'h0;
    // three low ticks exceed the dropout tolerance and the filter resets
    repeat (2500) @(posedge clk);
    #1;
    check(9'(dataEnabled), 9'h000);
    check(9'(alarm), 9'h000);
    // filter off again: data passes with no header at all
    regWrite(3'h0, 9'h000);
    repeat (3) @(posedge clk);
    #1;
    check(9'(dataEnabled), 9'h001);
    softReset;
    check(9'(pulses), 9'h001);
    #1;
    check(9'(dataEnabled), 9'h000);
    regRead(3'h7, rd);
    check(rd & 9'h01C, 9'h014);
    print_verdict;
  end
endmodule : lf_wakeup_header_filter_bench
